/* File: arp_host_model.sv */
// Host model that clocks a serial result in with its own shift clock
module arp_host_model (
  // Clock
  input wire logic i_clk,
  // Serial link
  input wire logic i_go,
  input wire logic i_ser,
  output logic o_sclk,
  output logic [9:0] o_word,
  output logic o_done
);
  timeunit 1ns;
  timeprecision 1ps;
  localparam int HALF = arp_pkg::SCLK_HALF_CYC + 1;
  // A bit shows three clocks after the pin fall; the last one is retired soon after
  localparam int SAMPLE = 4;
  initial begin
    o_sclk = 1'b0;
    o_word = 10'h000;
    o_done = 1'b0;
    forever begin
      @(posedge i_clk iff i_go);
      o_done <= 1'b0;
      for (int i = 0; i < 10; i++) begin
        o_sclk <= 1'b1;
        repeat (HALF) @(posedge i_clk);
        o_sclk <= 1'b0;
        repeat (SAMPLE) @(posedge i_clk);
        o_word <= {o_word[8:0], i_ser};
        repeat (HALF - SAMPLE) @(posedge i_clk);
      end
      o_sclk <= 1'b0;
      o_done <= 1'b1;
      @(posedge i_clk iff !i_go);
    end
  end
endmodule : arp_host_model

/* File: arp_pkg.sv */
// Shared constants and carrier types for the converter result output port
package arp_pkg;
  localparam int RESULT_W = 10;
  localparam int BYTE_W = 8;
  localparam int LOW_BITS = 2;
  localparam int SYNC_STAGES = 2;
  localparam int BUF_DEPTH = 2;
  localparam logic [9:0] RESULT_RST = 10'h000;
  localparam int CLK_PERIOD_NS = 8;
  localparam int SCLK_MAX_KHZ = 10000;
  // Least system cycles per shift-clock half period at the fastest legal shift clock
  localparam int SCLK_HALF_NS = 1000000 / SCLK_MAX_KHZ / 2;
  localparam int SCLK_HALF_CYC = (SCLK_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  typedef struct packed {
    logic [9:0] data;
  } arp_result_t;

  typedef struct packed {
    logic [9:0] data;
    logic [9:0] oe;
  } arp_par_t;
endpackage : arp_pkg

/* File: arp_result_port.sv */
// Result output port: two-entry buffer, parallel tri-state word or bytes, serial shifter
module arp_result_port (
  // Clock and reset
  input wire logic I_SYS_CLK,
  input wire logic I_RST,
  // Result stream from the conversion core
  input wire logic I_RES_VALID,
  output logic O_RES_READY,
  input wire arp_pkg::arp_result_t I_RES,
  // Conversion state from the core and start request to it
  input wire logic I_CONV_BUSY,
  output logic O_CONV_START,
  // Host pins
  input wire logic I_CHIP_SELECT_LOW,
  input wire logic I_READ_CONVERT,
  input wire logic I_WORD_FORMAT_SELECT,
  input wire logic I_BYTE_SELECT,
  input wire logic I_SCLK,
  // Host results
  output logic [9:0] O_PAR_DATA,
  output logic [9:0] O_PAR_OE,
  output logic O_SER_DATA,
  output logic O_SER_OE,
  output logic O_CONVERSION_DONE_LOW
);
  if (arp_pkg::BUF_DEPTH != 2 || arp_pkg::RESULT_W != 10 ||
      arp_pkg::SCLK_HALF_CYC < 1) begin : g_bad_cfg
    $error("arp_result_port: unsupported configuration");
  end

  //////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers
  localparam int NSYNC = 5;
  logic [NSYNC-1:0] pin_raw;
  logic [NSYNC-1:0] sync1_reg;
  logic [NSYNC-1:0] sync2_reg;
  assign pin_raw = {I_SCLK, I_BYTE_SELECT, I_WORD_FORMAT_SELECT, I_READ_CONVERT,
                    I_CHIP_SELECT_LOW};
  always_ff @(posedge I_SYS_CLK or posedge I_RST) begin
    if (I_RST) begin
      // Idle pin levels (deselected, read) so no false edge follows reset
      sync1_reg <= 5'h03;
      sync2_reg <= 5'h03;
    end else begin
      sync1_reg <= pin_raw;
      sync2_reg <= sync1_reg;
    end
  end
  logic cs_n;
  logic rd_conv;
  logic word_fmt;
  logic byte_sel;
  logic sclk_s;
  assign cs_n = sync2_reg[0];
  assign rd_conv = sync2_reg[1];
  assign word_fmt = sync2_reg[2];
  assign byte_sel = sync2_reg[3];
  assign sclk_s = sync2_reg[4];

  //////////////////////////////////////////////////////////////////////////////
  // Two-entry result buffer
  logic [9:0] buf_reg [arp_pkg::BUF_DEPTH];
  logic [9:0] buf_next [arp_pkg::BUF_DEPTH];
  logic [1:0] cnt_reg;
  logic [1:0] cnt_next;
  logic wr_ptr_reg;
  logic wr_ptr_next;
  logic rd_ptr_reg;
  logic rd_ptr_next;
  logic buf_pop;
  logic buf_push;
  assign O_RES_READY = (cnt_reg != 2'h2);
  assign buf_push = I_RES_VALID && O_RES_READY;
  always_comb begin
    buf_next = buf_reg;
    cnt_next = cnt_reg;
    wr_ptr_next = wr_ptr_reg;
    rd_ptr_next = rd_ptr_reg;
    if (buf_push) begin
      buf_next[wr_ptr_reg] = I_RES.data;
      wr_ptr_next = ~wr_ptr_reg;
    end
    if (buf_pop && cnt_reg != 2'h0) begin
      rd_ptr_next = ~rd_ptr_reg;
    end
    case ({buf_push, buf_pop && cnt_reg != 2'h0})
      2'b10: cnt_next = cnt_reg + 2'h1;
      2'b01: cnt_next = cnt_reg - 2'h1;
      default: cnt_next = cnt_reg;
    endcase
  end
  always_ff @(posedge I_SYS_CLK or posedge I_RST) begin
    if (I_RST) begin
      buf_reg[0] <= arp_pkg::RESULT_RST;
      buf_reg[1] <= arp_pkg::RESULT_RST;
      cnt_reg <= 2'h0;
      wr_ptr_reg <= 1'b0;
      rd_ptr_reg <= 1'b0;
    end else begin
      buf_reg <= buf_next;
      cnt_reg <= cnt_next;
      wr_ptr_reg <= wr_ptr_next;
      rd_ptr_reg <= rd_ptr_next;
    end
  end
  logic avail;
  logic [9:0] head;
  assign avail = (cnt_reg != 2'h0) && !I_CONV_BUSY;
  assign head = buf_reg[rd_ptr_reg];

  //////////////////////////////////////////////////////////////////////////////
  // Control: conversion request, parallel format, serial shifter
  function automatic logic [9:0] fmt_par(input logic [9:0] d, input logic wf, input logic bs);
    if (wf) begin
      fmt_par = d;
    end else if (!bs) begin
      fmt_par = {d[9:2], 2'b00};
    end else begin
      fmt_par = {d[1:0], 8'h00};
    end
  endfunction : fmt_par

  logic rd_conv_d_reg;
  logic sclk_d_reg;
  logic start_reg;
  logic start_next;
  logic [9:0] par_reg;
  logic [9:0] par_next;
  logic par_oe_reg;
  logic par_oe_next;
  logic ser_reg;
  logic ser_next;
  logic ser_oe_reg;
  logic ser_oe_next;
  logic [9:0] shift_reg;
  logic [9:0] shift_next;
  logic [3:0] bits_reg;
  logic [3:0] bits_next;
  logic eoc_n_reg;
  logic eoc_n_next;
  logic sclk_fall;
  assign sclk_fall = sclk_d_reg && !sclk_s;
  always_comb begin
    start_next = !cs_n && rd_conv_d_reg && !rd_conv;
    par_next = fmt_par(head, word_fmt, byte_sel);
    par_oe_next = !cs_n && rd_conv && avail;
    eoc_n_next = !avail;
    ser_oe_next = !cs_n;
    shift_next = shift_reg;
    bits_next = bits_reg;
    ser_next = ser_reg;
    buf_pop = 1'b0;
    if (!avail) begin
      ser_next = 1'b0;
      bits_next = 4'h0;
    end else if (bits_reg == 4'h0) begin
      ser_next = 1'b1;
      shift_next = head;
      bits_next = 4'h1;
    end else if (!cs_n && sclk_fall) begin
      ser_next = shift_reg[9];
      shift_next = {shift_reg[8:0], 1'b0};
      bits_next = bits_reg + 4'h1;
    end
    // Retire the word once all ten bits went out or a word or low-byte parallel read ended
    // A stall by the core (busy) must not count as the end of a read
    if ((bits_reg == 4'hb) || (par_oe_reg && (cs_n || !rd_conv) && (word_fmt || byte_sel))) begin
      buf_pop = 1'b1;
      bits_next = 4'h0;
    end
  end
  always_ff @(posedge I_SYS_CLK or posedge I_RST) begin
    if (I_RST) begin
      rd_conv_d_reg <= 1'b1;
      sclk_d_reg <= 1'b0;
      start_reg <= 1'b0;
      par_reg <= arp_pkg::RESULT_RST;
      par_oe_reg <= 1'b0;
      ser_reg <= 1'b0;
      ser_oe_reg <= 1'b0;
      shift_reg <= arp_pkg::RESULT_RST;
      bits_reg <= 4'h0;
      eoc_n_reg <= 1'b1;
    end else begin
      rd_conv_d_reg <= rd_conv;
      sclk_d_reg <= sclk_s;
      start_reg <= start_next;
      par_reg <= par_next;
      par_oe_reg <= par_oe_next;
      ser_reg <= ser_next;
      ser_oe_reg <= ser_oe_next;
      shift_reg <= shift_next;
      bits_reg <= bits_next;
      eoc_n_reg <= eoc_n_next;
    end
  end
  assign O_CONV_START = start_reg;
  assign O_PAR_DATA = par_reg;
  assign O_PAR_OE = {10{par_oe_reg}};
  assign O_SER_DATA = ser_reg;
  assign O_SER_OE = ser_oe_reg;
  assign O_CONVERSION_DONE_LOW = eoc_n_reg;

  //////////////////////////////////////////////////////////////////////////////
  // Checks
  chk_ser_hiz: assert property (@(posedge I_SYS_CLK) disable iff (I_RST)
    cs_n |=> !O_SER_OE) else $error("serial output driven while deselected");
  chk_ser_low_busy: assert property (@(posedge I_SYS_CLK) disable iff (I_RST)
    (I_CONV_BUSY ##1 I_CONV_BUSY) |-> !O_SER_DATA) else $error("serial high during conversion");
  chk_eoc_flag: assert property (@(posedge I_SYS_CLK) disable iff (I_RST)
    I_CONV_BUSY |=> O_CONVERSION_DONE_LOW) else $error("done flag low while converting");
  chk_msb_first: assert property (@(posedge I_SYS_CLK) disable iff (I_RST)
    (avail && bits_reg == 4'h1 && !cs_n && sclk_fall) |=> O_SER_DATA == $past(shift_reg[9]))
    else $error("serial bit order wrong");
  chk_byte_low: assert property (@(posedge I_SYS_CLK) disable iff (I_RST)
    (!word_fmt && byte_sel) |=> O_PAR_DATA[7:0] == 8'h00) else $error("middle bits not zero");
  chk_word_fmt: assert property (@(posedge I_SYS_CLK) disable iff (I_RST)
    word_fmt |=> O_PAR_DATA == $past(head)) else $error("word format mismatch");
  chk_par_oe: assert property (@(posedge I_SYS_CLK) disable iff (I_RST)
    cs_n |=> O_PAR_OE == 10'h000) else $error("parallel driven while deselected");
  chk_shift_step: assert property (@(posedge I_SYS_CLK) disable iff (I_RST)
    (avail && bits_reg inside {[4'h1:4'ha]} && !cs_n && sclk_fall && !buf_pop)
    |=> bits_reg == $past(bits_reg) + 4'h1) else $error("shift count did not advance");
endmodule : arp_result_port

/* File: arp_result_port_test.sv */
// Self-checking bench for the result output port
module arp_result_port_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic valid = 1'b0;
  logic busy = 1'b0;
  logic cs_low = 1'b1;
  logic rc = 1'b1;
  logic wfs = 1'b1;
  logic bs = 1'b0;
  logic go = 1'b0;
  arp_pkg::arp_result_t res = '0;
  logic ready, start, sclk, ser, ser_oe, done_low, hdone;
  logic [9:0] pdata, poe, hword;
  logic ser_pin;
  // Released serial line shows the inverse level to the host
  assign ser_pin = ser_oe ? ser : !ser;
  int err_total = 0;
  int total_checks = 0;
  int cyc = 0;
  int n;
  always #4 clk = ~clk;
  arp_result_port u_arp_result_port (.I_SYS_CLK(clk), .I_RST(rst), .I_RES_VALID(valid),
    .O_RES_READY(ready), .I_RES(res), .I_CONV_BUSY(busy), .O_CONV_START(start),
    .I_CHIP_SELECT_LOW(cs_low), .I_READ_CONVERT(rc), .I_WORD_FORMAT_SELECT(wfs),
    .I_BYTE_SELECT(bs), .I_SCLK(sclk), .O_PAR_DATA(pdata), .O_PAR_OE(poe),
    .O_SER_DATA(ser), .O_SER_OE(ser_oe), .O_CONVERSION_DONE_LOW(done_low));
  arp_host_model u_arp_host_model (.i_clk(clk), .i_go(go), .i_ser(ser_pin), .o_sclk(sclk),
    .o_word(hword), .o_done(hdone));
  task wrap_up;
    if (err_total == 0 && total_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : wrap_up
  task chk_word(input string name, input logic [9:0] exp, input logic [9:0] got);
    total_checks++;
    if (got !== exp) begin
      err_total++;
      $display("unexpected %s expected %h seen %h", name, exp, got);
    end
  endtask : chk_word
  task chk_bit(input string name, input logic exp, input logic got);
    total_checks++;
    if (got !== exp) begin
      err_total++;
      $display("unexpected %s expected %b seen %b", name, exp, got);
    end
  endtask : chk_bit
  // Ends at a falling edge so that registered outputs have settled
  task step(input int k);
    repeat (k) @(negedge clk);
  endtask : step
  task push(input logic [9:0] w);
    @(posedge clk);
    res.data <= w;
    valid <= 1'b1;
    @(posedge clk);
    valid <= 1'b0;
  endtask : push
  always @(posedge clk) begin
    cyc++;
    if (cyc == 3000) begin
      err_total++;
      wrap_up();
    end
  end
  initial begin
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    step(4);
    chk_bit("ser_oe", 1'b0, ser_oe);
    chk_word("par_oe", 10'h000, poe);
    chk_bit("done_low", 1'b1, done_low);
    push(10'h2a5);
    step(2);
    chk_bit("done_low", 1'b0, done_low);
    @(posedge clk);
    cs_low <= 1'b0;
    step(6);
    chk_bit("ser_oe", 1'b1, ser_oe);
    chk_bit("ser_marker", 1'b1, ser);
    @(posedge clk);
    go <= 1'b1;
    for (int i = 0; i < 400 && hdone !== 1'b1; i++) @(posedge clk);
    go <= 1'b0;
    chk_bit("host_done", 1'b1, hdone);
    chk_word("ser_word", 10'h2a5, hword);
    step(4);
    chk_bit("done_low", 1'b1, done_low);
    @(posedge clk);
    busy <= 1'b1;
    step(5);
    chk_bit("ser_busy", 1'b0, ser);
    @(posedge clk);
    rc <= 1'b0;
    n = 0;
    repeat (8) begin
      @(negedge clk);
      if (start === 1'b1) n++;
    end
    chk_word("conv_start", 10'h001, 10'(n));
    @(posedge clk);
    rc <= 1'b1;
    busy <= 1'b0;
    cs_low <= 1'b1;
    push(10'h3c6);
    @(posedge clk);
    cs_low <= 1'b0;
    step(6);
    chk_word("par_word", 10'h3c6, pdata);
    chk_word("par_oe", 10'h3ff, poe);
    @(posedge clk);
    cs_low <= 1'b1;
    step(6);
    chk_word("par_oe", 10'h000, poe);
    chk_bit("done_low", 1'b1, done_low);
    push(10'h2d9);
    @(posedge clk);
    wfs <= 1'b0;
    cs_low <= 1'b0;
    step(6);
    chk_word("par_hi", 10'h2d8, pdata);
    @(posedge clk);
    bs <= 1'b1;
    step(6);
    chk_word("par_lo", 10'h100, pdata);
    @(posedge clk);
    cs_low <= 1'b1;
    wfs <= 1'b1;
    step(6);
    chk_bit("done_low", 1'b1, done_low);
    push(10'h111);
    push(10'h222);
    step(1);
    chk_bit("ready_full", 1'b0, ready);
    for (int i = 0; i < 2; i++) begin
      @(posedge clk);
      cs_low <= 1'b0;
      step(6);
      chk_word("par_order", i ? 10'h222 : 10'h111, pdata);
      @(posedge clk);
      cs_low <= 1'b1;
      step(6);
    end
    chk_bit("ready_empty", 1'b1, ready);
    wrap_up();
  end
endmodule : arp_result_port_test
